/* File: pkg/ivm_defs.svh */
// Constants for the interrupt vector mapper: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the top module.
// What this block does
// - Source event sets its sticky flag bit
// - Enable register bit gates each source but the unmaskable scan
// - Request needs flag and enable both set
// - Request stays high until flag cleared
// - Global enable gates all maskable core requests, not irq_out
// - One vector per source; timer A, timer D, converter, I2C and serial port have several
// - Vector 0 reset, vector 1 unmaskable scan
// - Vectors 2-7: monitor, ports, counter, timer
// - Vectors 8-9 follow timer A split mode
// - Vectors 10-12: timer A compare channels
// - Vectors 13-15: timer B, timer D pair
// - Vectors 16-18: comparator and converter events
// - Vectors 19-21: I2C client, host, SPI
// - Vectors 22-25: serial port and EEPROM
// - Port C vector only on 20+ pins
// - Revision identifier readable by the processor
// - Revision reads 8 bits, zero means first
`ifndef IVM_DEFS_SVH
`define IVM_DEFS_SVH

// Register byte offsets on the APB window
`define IVM_OFS_FLAG    12'h000
`define IVM_OFS_ENABLE  12'h004
`define IVM_OFS_CTRL    12'h008
`define IVM_OFS_STATUS  12'h00c
`define IVM_OFS_REVISION_NUMBER   12'h010

// Control register fields
`define IVM_CTRL_GIE    0
`define IVM_CTRL_SPLIT  1
`define IVM_CTRL_RST    2'h0
`define IVM_FLAG_RST    32'h0000_0000
`define IVM_EN_RST      32'h0000_0000

// Status register fields
`define IVM_STAT_REQ    8
`define IVM_STAT_REQ_RST 1'h0

// Revision: zero is the first revision
`define IVM_REV_ID      8'h00

// Package variant and the least pin count with port C
`define IVM_PIN_COUNT   20
`define IVM_PORTC_PINS  20

// Vector numbers, equal to the word address of each entry
`define IVM_VEC_RESET   0
`define IVM_VEC_NMI     1
`define IVM_VEC_VLM     2
`define IVM_VEC_PORTA   3
`define IVM_VEC_PORTB   4
`define IVM_VEC_PORTC   5
`define IVM_VEC_RTCNT   6
`define IVM_VEC_PIT     7
`define IVM_VEC_TAOVF   8
`define IVM_VEC_TAHUNF  9
`define IVM_VEC_TACMP0  10
`define IVM_VEC_TBCAP   13
`define IVM_VEC_TDOVF   14
`define IVM_VEC_TDTRIG  15
`define IVM_VEC_COMP    16
`define IVM_VEC_RESRDY  17
`define IVM_VEC_WINDOW  18
`define IVM_VEC_I2CC    19
`define IVM_VEC_I2CH    20
`define IVM_VEC_SPI     21
`define IVM_VEC_RXC     22
`define IVM_VEC_DRE     23
`define IVM_VEC_TXC     24
`define IVM_VEC_EE      25
`define IVM_VEC_LAST    25

`endif

/* File: pkg/ivm_pkg.sv */
// Types shared by the interrupt vector mapper files.
// Assumes ivm_defs.svh is on the include path.
`include "ivm_defs.svh"

package ivm_pkg;

    // One event strobe per peripheral interrupt source
    typedef struct packed {
        logic crc_scanner_nonmaskable;
        logic voltage_level_monitor_irq;
        logic port_a_change_irq;
        logic port_b_change_irq;
        logic port_c_change_irq;
        logic realtime_counter_irq;
        logic periodic_timer_irq;
        logic timer_a_overflow_irq;
        logic timer_a_low_underflow_irq;
        logic timer_a_high_underflow_irq;
        logic [2:0] timer_a_compare_irq;
        logic [2:0] timer_a_low_compare_irq;
        logic timer_b_capture_irq;
        logic timer_d_overflow_irq;
        logic timer_d_trigger_irq;
        logic comparator_irq;
        logic converter_result_ready_irq;
        logic converter_window_irq;
        logic i2c_client_irq;
        logic i2c_host_irq;
        logic spi_irq;
        logic serial_rx_complete_irq;
        logic serial_tx_empty_irq;
        logic serial_tx_complete_irq;
        logic eeprom_ready_irq;
    } ivm_src_t;

    // Request presented to the processor core
    typedef struct packed {
        logic        req;
        logic [4:0]  vec;
        logic [15:0] addr;
    } ivm_core_t;

    // APB slave phase
    typedef enum logic {
        IVM_ST_IDLE = 1'b0,
        IVM_ST_ACC  = 1'b1
    } ivm_apb_st_t;

endpackage

/* File: rtl/ivm_prio_enc.sv */
// Lowest-index-first priority encoder over the pending vectors.
// Assumes a purely combinational use; the caller registers the result.
`include "ivm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ivm_prio_enc
    import ivm_pkg::*;
(
    input  wire logic [31:0] pend,
    output logic             any,
    output logic [4:0]       idx
);

    // Scan from the top down so the lowest set bit is written last
    always_comb begin
        any = 1'b0;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (pend[i]) begin
                any = 1'b1;
                idx = 5'(i);
            end
        end
    end

endmodule

`default_nettype wire

/* File: rtl/ivm_top.sv */
// Interrupt vector mapper: per-vector flags and enables, global gate,
// vector choice and an APB register window.
// Assumes zero-wait APB3 master, source strobes synchronous to pclk.
`include "ivm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ivm_top
    import ivm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire ivm_src_t    src_evt,
    output ivm_core_t        core_req,
    output logic             irq_out
);

    // Stored register state
    logic [31:0] flag_ff;     // irq_flag_reg, one sticky bit per vector
    logic [31:0] en_ff;       // irq_enable_reg, one bit per vector
    logic [1:0]  ctrl_ff;     // Global enable and timer A split mode

    // APB answer flops
    ivm_apb_st_t st_ff;       // Slave phase
    logic [31:0] prdata_ff;   // Read data, loaded in setup
    logic        pready_ff;   // High for the single access cycle
    logic        pslverr_ff;  // Unmapped address seen in setup

    // Core side flops
    ivm_core_t   core_ff;     // Registered request, vector, address
    logic        irq_out_ff;  // Any unmasked flag

    // Combinational helpers
    logic [31:0] vec_evt;     // Event per vector after mode muxing
    logic [31:0] vec_impl;    // Vectors that exist on this variant
    logic [31:0] en_eff;      // Enables with the NMI forced on
    logic [31:0] gate;        // Global enable mask
    logic [31:0] pend;        // Requests eligible for the core
    logic [31:0] w1c;         // Flag bits cleared this cycle
    logic        acc_wr;      // Completing write to a mapped word
    logic        setup;       // Setup cycle of a new transfer
    logic        hit;         // Address decodes to a register
    logic [31:0] rd_mux;      // Read data before the flop
    logic        any;         // Some request is eligible
    logic [4:0]  idx;         // Lowest eligible vector

    // Outputs come straight from flops
    assign prdata   = prdata_ff;
    assign pready   = pready_ff;
    assign pslverr  = pslverr_ff;
    assign core_req = core_ff;
    assign irq_out  = irq_out_ff;

    // Control bits used across the block
    logic gie;
    logic split;
    assign gie   = ctrl_ff[`IVM_CTRL_GIE];
    assign split = ctrl_ff[`IVM_CTRL_SPLIT];

    // Map each source onto its one vector; a vector never serves two
    // peripherals, so only timer A needs a mode mux
    always_comb begin
        vec_evt = 32'h0000_0000;
        // Vector 0 is the reset entry and never flags
        vec_evt[`IVM_VEC_RESET]  = 1'b0;
        vec_evt[`IVM_VEC_NMI]    = src_evt.crc_scanner_nonmaskable;
        // Low system vectors in fixed order
        vec_evt[`IVM_VEC_VLM]    = src_evt.voltage_level_monitor_irq;
        vec_evt[`IVM_VEC_PORTA]  = src_evt.port_a_change_irq;
        vec_evt[`IVM_VEC_PORTB]  = src_evt.port_b_change_irq;
        vec_evt[`IVM_VEC_PORTC]  = src_evt.port_c_change_irq;
        vec_evt[`IVM_VEC_RTCNT]  = src_evt.realtime_counter_irq;
        vec_evt[`IVM_VEC_PIT]    = src_evt.periodic_timer_irq;
        // Timer A overflow or split-mode underflows
        if (split) begin
            vec_evt[`IVM_VEC_TAOVF]  = src_evt.timer_a_low_underflow_irq;
            vec_evt[`IVM_VEC_TAHUNF] = src_evt.timer_a_high_underflow_irq;
        end else begin
            // Vector 9 has no source in normal mode
            vec_evt[`IVM_VEC_TAOVF]  = src_evt.timer_a_overflow_irq;
            vec_evt[`IVM_VEC_TAHUNF] = 1'b0;
        end
        // Compare channels 0 to 2, low byte ones when split
        if (split) begin
            vec_evt[`IVM_VEC_TACMP0 +: 3] = src_evt.timer_a_low_compare_irq;
        end else begin
            vec_evt[`IVM_VEC_TACMP0 +: 3] = src_evt.timer_a_compare_irq;
        end
        // Timer B and timer D
        vec_evt[`IVM_VEC_TBCAP]  = src_evt.timer_b_capture_irq;
        vec_evt[`IVM_VEC_TDOVF]  = src_evt.timer_d_overflow_irq;
        vec_evt[`IVM_VEC_TDTRIG] = src_evt.timer_d_trigger_irq;
        // Analog group
        vec_evt[`IVM_VEC_COMP]   = src_evt.comparator_irq;
        vec_evt[`IVM_VEC_RESRDY] = src_evt.converter_result_ready_irq;
        vec_evt[`IVM_VEC_WINDOW] = src_evt.converter_window_irq;
        // Serial buses
        vec_evt[`IVM_VEC_I2CC]   = src_evt.i2c_client_irq;
        vec_evt[`IVM_VEC_I2CH]   = src_evt.i2c_host_irq;
        vec_evt[`IVM_VEC_SPI]    = src_evt.spi_irq;
        // Serial port and memory controller
        vec_evt[`IVM_VEC_RXC]    = src_evt.serial_rx_complete_irq;
        vec_evt[`IVM_VEC_DRE]    = src_evt.serial_tx_empty_irq;
        vec_evt[`IVM_VEC_TXC]    = src_evt.serial_tx_complete_irq;
        vec_evt[`IVM_VEC_EE]     = src_evt.eeprom_ready_irq;
    end

    // Which vectors exist; unused bits read zero and never flag
    always_comb begin
        vec_impl = 32'h0000_0000;
        for (int v = `IVM_VEC_NMI; v <= `IVM_VEC_LAST; v++) begin
            vec_impl[v] = 1'b1;
        end
        // Small packages lack port C, so its vector stays idle
        if (`IVM_PIN_COUNT < `IVM_PORTC_PINS) begin
            vec_impl[`IVM_VEC_PORTC] = 1'b0;
        end
    end

    // The scan vector cannot be masked by any bit
    always_comb begin
        en_eff = en_ff & vec_impl;
        en_eff[`IVM_VEC_NMI] = 1'b1;
    end

    // Global gate passes only the NMI when cleared
    always_comb begin
        gate = 32'h0000_0000;
        gate[`IVM_VEC_NMI] = 1'b1;
        if (gie) begin
            gate = 32'hffff_ffff;
        end
    end

    // Eligible requests: flag and enable both set
    assign pend = flag_ff & en_eff & gate;

    // APB decode helpers
    assign setup  = psel & ~penable;
    assign acc_wr = psel & penable & pready_ff & pwrite & ~pslverr_ff;

    // Address decode of the five words
    always_comb begin
        case (paddr)
            `IVM_OFS_FLAG:   hit = 1'b1;
            `IVM_OFS_ENABLE: hit = 1'b1;
            `IVM_OFS_CTRL:   hit = 1'b1;
            `IVM_OFS_STATUS: hit = 1'b1;
            `IVM_OFS_REVISION_NUMBER:  hit = 1'b1;
            default:         hit = 1'b0;
        endcase
    end

    // Write-one-to-clear mask for the flag word
    always_comb begin
        w1c = 32'h0000_0000;
        if (acc_wr && paddr == `IVM_OFS_FLAG) begin
            w1c = pwdata;
        end
    end

    // One flop per vector flag; a new event beats a clear in the same
    // cycle so no event is ever lost
    for (genvar g = 0; g < 32; g++) begin : g_flag
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flag_ff[g] <= 1'b0;
            end else if (vec_impl[g] && vec_evt[g]) begin
                flag_ff[g] <= 1'b1;
            end else if (w1c[g]) begin
                flag_ff[g] <= 1'b0; // Held until software clears
            end
        end
    end

    // Enable word, one bit per vector source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= `IVM_EN_RST;
        end else if (acc_wr && paddr == `IVM_OFS_ENABLE) begin
            en_ff <= pwdata & vec_impl;
        end
    end

    // Control word: global enable and timer A split mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `IVM_CTRL_RST;
        end else if (acc_wr && paddr == `IVM_OFS_CTRL) begin
            ctrl_ff <= pwdata[1:0];
        end
    end

    // Read mux, sampled in the setup cycle
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `IVM_OFS_FLAG: begin
                rd_mux = flag_ff;
            end
            `IVM_OFS_ENABLE: begin
                rd_mux = en_eff;
            end
            `IVM_OFS_CTRL: begin
                rd_mux[1:0] = ctrl_ff;
            end
            `IVM_OFS_STATUS: begin
                // Shows what the core is being offered now
                rd_mux[4:0] = core_ff.vec;
                rd_mux[`IVM_STAT_REQ] = core_ff.req;
            end
            `IVM_OFS_REVISION_NUMBER: begin
                rd_mux[7:0] = `IVM_REV_ID;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // APB phase machine: every transfer answers in its first access
    // cycle; read data is a snapshot taken at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff      <= IVM_ST_IDLE;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            case (st_ff)
                IVM_ST_IDLE: begin
                    if (setup) begin
                        st_ff      <= IVM_ST_ACC;
                        pready_ff  <= 1'b1;
                        pslverr_ff <= ~hit;
                        prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
                    end
                end
                IVM_ST_ACC: begin
                    // Access completes at this edge; drop the answer
                    st_ff      <= IVM_ST_IDLE;
                    pready_ff  <= 1'b0;
                    pslverr_ff <= 1'b0;
                end
                default: begin
                    st_ff     <= IVM_ST_IDLE;
                    pready_ff <= 1'b0;
                end
            endcase
        end
    end

    // Lowest pending vector first
    ivm_prio_enc u_enc (
        .pend (pend),
        .any  (any),
        .idx  (idx)
    );

    // Core request flops; the request is a level that follows the flag,
    // so it falls one edge after the flag is cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ff.req  <= `IVM_STAT_REQ_RST;
            core_ff.vec  <= 5'h00;
            core_ff.addr <= 16'h0000;
        end else begin
            core_ff.req  <= any;
            core_ff.vec  <= idx;
            // Word address is the vector number itself
            core_ff.addr <= {11'h000, idx};
        end
    end

    // Interrupt line: any flag whose enable is set, ignoring the
    // global gate so software can poll with interrupts off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out_ff <= 1'b0;
        end else begin
            irq_out_ff <= |(flag_ff & en_eff);
        end
    end

    // A peripheral with many causes ORs them onto its one strobe
    // before this block, so each vector has one flag

endmodule

`default_nettype wire

/* File: testbench/ivm_checker.sv */
// Port checker for the vector mapper: APB answer, request shape, NMI path.
// Assumes a bind to ivm_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ivm_checker
    import ivm_pkg::*;
(
    input wire logic     pclk,
    input wire logic     presetn,
    input wire logic     psel,
    input wire logic     penable,
    input wire logic     pready,
    input wire logic     pslverr,
    input wire ivm_src_t src_evt,
    input wire ivm_core_t core_req,
    input wire logic     irq_out
);
    // Single domain: one clock and one disable for every property
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_addr_is_vec: assert property (core_req.req |-> core_req.addr == {11'h0, core_req.vec})
        else $error("fetch address differs from vector");
    a_no_reset_vec: assert property (core_req.req |-> core_req.vec != 5'h0)
        else $error("vector zero requested");
    a_vec_in_table: assert property (core_req.req |-> core_req.vec <= 5'h19)
        else $error("vector beyond table");
    a_req_has_irq: assert property (core_req.req |-> irq_out)
        else $error("request without enabled flag");
    // No write one cycle back means no flag was cleared, so the level holds
    a_req_held: assert property (core_req.req && !$past(psel) |=> core_req.req)
        else $error("request dropped without a clear");
    a_nmi_reqs: assert property (src_evt.crc_scanner_nonmaskable |-> ##2 core_req.req)
        else $error("unmaskable event gave no request");
    a_quiet_rel: assert property ($rose(presetn) |-> !core_req.req && !irq_out)
        else $error("request right after reset");
    a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a one-cycle answer");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");

    c_nmi: cover property (core_req.req && core_req.vec == 5'h01);
    c_timer_b: cover property (core_req.req && core_req.vec == 5'h0d);
    c_slverr: cover property (pslverr);
endmodule
`default_nettype wire

/* File: testbench/ivm_core_model.sv */
// Processor core stand-in: fetches the entry word of the pending vector.
// Assumes core_req comes straight from ivm_top.
`timescale 1ns/1ps
`default_nettype none
module ivm_core_model
    import ivm_pkg::*;
(
    input wire logic      pclk,
    input wire logic      presetn,
    input wire ivm_core_t core_req,
    output logic [15:0]   fetch_addr_ff
);
    // Latch the word address whenever a request is presented
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_addr_ff <= 16'h0000;
        end else if (core_req.req) begin
            fetch_addr_ff <= core_req.addr;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/ivm_top_test.sv */
// Self-checking bench for ivm_top: registers, source map, request path.
// Assumes the checker and core model files are compiled first.
`include "ivm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ivm_top_test;
    import ivm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    ivm_src_t    src_evt;
    ivm_core_t   core_req;
    logic [15:0] fetch_addr;
    int          mismatches, check_count, cyc;

    ivm_top ivm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_evt(src_evt), .core_req(core_req), .irq_out(irq_out));
    ivm_core_model ivm_core_model_inst (.pclk(pclk), .presetn(presetn),
        .core_req(core_req), .fetch_addr_ff(fetch_addr));

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Hang guard, far above the under one thousand cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high at a
    // rising edge, and data and error are taken at that very edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        q = prdata;
        e = pslverr;
        if (n == 16) chk(32'h1, 32'h0, "no pready");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ex);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x, "read data");
        chk({31'h0, e}, {31'h0, ex}, "pslverr");
    endtask
    // Strobe one source bit for one cycle, then let flag and request land
    task automatic pulse(input int b);
        @(posedge pclk);
        src_evt <= ivm_src_t'(29'h1 << b);
        @(posedge pclk);
        src_evt <= '0;
        settle();
    endtask
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask
    // Flag mask a struct bit should set; bit 28 is the unmaskable source
    function automatic logic [31:0] emap(int b, logic s);
        int v;
        v = 0;
        if (b >= 22) v = 29 - b;
        else if (b == 21) v = s ? 0 : 8;
        else if (b == 20) v = s ? 8 : 0;
        else if (b == 19) v = s ? 9 : 0;
        else if (b >= 16) v = s ? 0 : b - 6;
        else if (b >= 13) v = s ? b - 3 : 0;
        else v = 25 - b;
        return (v == 0) ? 32'h0 : (32'h1 << v);
    endfunction

    task automatic test_reset();
        rd(`IVM_OFS_FLAG, 32'h0, 1'b0);
        rd(`IVM_OFS_ENABLE, 32'h2, 1'b0);
        rd(`IVM_OFS_CTRL, 32'h0, 1'b0);
        wr(`IVM_OFS_REVISION_NUMBER, 32'hff);
        rd(`IVM_OFS_REVISION_NUMBER, 32'h0, 1'b0);
        rd(12'h020, 32'h0, 1'b1);
        $display("test_reset done");
    endtask
    // Every source in both timer A modes lands on its own vector bit; timer A sources of the other mode set none
    task automatic test_map();
        for (int s = 0; s < 2; s++) begin
            wr(`IVM_OFS_CTRL, {30'h0, s[0], 1'b0});
            for (int b = 0; b < 29; b++) begin
                pulse(b);
                rd(`IVM_OFS_FLAG, emap(b, s[0]), 1'b0);
                wr(`IVM_OFS_FLAG, 32'hffff_ffff);
            end
        end
        rd(`IVM_OFS_FLAG, 32'h0, 1'b0);
        wr(`IVM_OFS_CTRL, 32'h0);
        $display("test_map done");
    endtask
    // Gating, level hold, lowest vector first, fetch address
    task automatic test_req();
        wr(`IVM_OFS_ENABLE, 32'h2000);
        pulse(12);
        chk({31'h0, irq_out}, 32'h1, "irq level");
        chk({31'h0, core_req.req}, 32'h0, "req without global");
        wr(`IVM_OFS_CTRL, 32'h1);
        settle();
        chk({26'h0, core_req.req, core_req.vec}, 32'h2d, "req timer b");
        chk({16'h0, fetch_addr}, 32'hd, "fetch address");
        pulse(27);
        repeat (8) @(posedge pclk);
        #1;
        chk({26'h0, core_req.req, core_req.vec}, 32'h2d, "held, masked source");
        wr(`IVM_OFS_ENABLE, 32'h2004);
        settle();
        rd(`IVM_OFS_STATUS, 32'h102, 1'b0);
        wr(`IVM_OFS_FLAG, 32'h4);
        settle();
        chk({27'h0, core_req.vec}, 32'hd, "after clearing 2");
        wr(`IVM_OFS_FLAG, 32'h2000);
        settle();
        chk({30'h0, core_req.req, irq_out}, 32'h0, "after clearing 13");
        $display("test_req done");
    endtask
    task automatic test_nmi();
        wr(`IVM_OFS_CTRL, 32'h0);
        pulse(28);
        chk({26'h0, core_req.req, core_req.vec}, 32'h21, "nmi unmasked");
        wr(`IVM_OFS_FLAG, 32'h2);
        settle();
        chk({31'h0, core_req.req}, 32'h0, "nmi cleared");
        $display("test_nmi done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; src_evt = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_map();
        test_req();
        test_nmi();
        finish_test();
    end
endmodule

bind ivm_top ivm_checker ivm_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .src_evt(src_evt),
    .core_req(core_req), .irq_out(irq_out));
`default_nettype wire
